//--- rtl/eim_pkg.sv
// Shared constants and types for the error line mask and auto-command error block
package eim_pkg;

    // ----------------------------------------------------------------
    // Register map (index kept, byte address is four times the index)
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned REG_IDX_LINE_EN = 32'h3a;
    localparam int unsigned REG_IDX_ACMD_ST = 32'h3c;
    localparam logic [ADDR_W-1:0] ADDR_LINE_EN = ADDR_W'(4 * REG_IDX_LINE_EN);
    localparam logic [ADDR_W-1:0] ADDR_ACMD_ST = ADDR_W'(4 * REG_IDX_ACMD_ST);

    // ----------------------------------------------------------------
    // Line enable fields
    // ----------------------------------------------------------------
    localparam int unsigned EN_CMD_TIMEOUT = 0;
    localparam int unsigned EN_CMD_CRC = 1;
    localparam int unsigned EN_CMD_END_BIT = 2;
    localparam int unsigned EN_CMD_INDEX = 3;
    localparam int unsigned EN_DATA_TIMEOUT = 4;
    localparam int unsigned EN_DATA_CRC = 5;
    localparam int unsigned EN_DATA_END_BIT = 6;
    localparam int unsigned EN_CURRENT_LIMIT = 7;
    localparam int unsigned EN_AUTO_CMD = 8;
    localparam int unsigned EN_DESCRIPTOR_DMA = 9;
    localparam int unsigned EN_TUNING = 10;
    localparam int unsigned EN_RSVD = 11;
    localparam logic [15:0] LINE_EN_RESET = 16'h0000;
    localparam logic [15:0] LINE_EN_WMASK = 16'hf7ff;

    // ----------------------------------------------------------------
    // Auto-command status fields
    // ----------------------------------------------------------------
    localparam int unsigned ST_NOT_EXECUTED = 0;
    localparam int unsigned ST_TIMEOUT = 1;
    localparam int unsigned ST_CRC = 2;
    localparam int unsigned ST_END_BIT = 3;
    localparam int unsigned ST_INDEX = 4;
    localparam int unsigned ST_CMD_NOT_ISSUED = 7;
    localparam logic [4:0] ST_LO_RESET = 5'h00;
    localparam logic ST_B7_RESET = 1'b0;

    // ----------------------------------------------------------------
    // Timing and bus answers
    // ----------------------------------------------------------------
    localparam int unsigned RESP_TIMEOUT_CARD_CLKS = 64;
    localparam int unsigned TMR_W = 7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Joint decode of the CRC and timeout bits
    typedef enum logic [1:0] {
        EIM_FAULT_NONE,
        EIM_FAULT_TIMEOUT,
        EIM_FAULT_CRC,
        EIM_FAULT_CONFLICT
    } eim_fault_t;

    // Events from the command engine, one-cycle pulses except is_cmd23/blocked/xfer_started
    typedef struct packed {
        logic issue_req;
        logic blocked;
        logic xfer_started;
        logic is_cmd23;
        logic cmd_end;
        logic resp_end;
        logic index_err;
        logic end_bit_err;
        logic crc_err;
    } eim_acmd_ev_t;

endpackage

//--- rtl/eim_resp_timer.sv
// Response timeout counter in card clock cycles
`timescale 1ns/1ps
module eim_resp_timer #(
    parameter int unsigned LIMIT = eim_pkg::RESP_TIMEOUT_CARD_CLKS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic stop,
    input wire logic tick,
    output logic expired
);

    logic [eim_pkg::TMR_W-1:0] cnt_reg;
    logic run_reg;
    logic last_tick;

    assign last_tick = run_reg && tick && (cnt_reg == eim_pkg::TMR_W'(LIMIT - 1));

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    // Count ticks from the command end bit until response or limit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
        end else if (start) begin
            cnt_reg <= '0;
            run_reg <= 1'b1;
        end else if (stop || last_tick) begin
            run_reg <= 1'b0;
        end else if (run_reg && tick) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // Expiry pulse, one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            expired <= 1'b0;
        end else begin
            expired <= last_tick && !stop && !start;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_TMR_LIMIT: assert property (@(posedge aclk) disable iff (!aresetn)
        expired |-> $past(cnt_reg) == eim_pkg::TMR_W'(LIMIT - 1) && $past(tick))
        else $error("timer expired at wrong count");

endmodule // eim_resp_timer

//--- rtl/eim_err_irq.sv
// Error line masking and auto-command error status with AXI4-Lite registers
`timescale 1ns/1ps
// How it works
// - One shared error line; each status reaches it only when enabled.
// - Enable layout fixed; bit 11 reserved and reads zero.
// - Block-count command errors use only status bits 4 to 1.
// - Bit 7 set on queued command blocked by stop error; cleared for block-count.
// - Bit 4 set on wrong command index in auto-command response.
// - Bit 3 set when response end bit sampled as zero.
// - Bit 2 set when response CRC check fails.
// - Bit 1 set when no response within 64 card clocks of end bit.
// - Bit 0 set when stop command cannot be issued; clear for block-count.
// - Bit 0 stays clear when the multi-block transfer never started.
// - CRC and timeout bits decode jointly: none, timeout, CRC, line conflict.
// - Before issuing stop command, bit 0 set if blocked after transfer start, else cleared.
// - At response end bit, bits 1 to 4 written set or clear.
// - Bit 7 updated just before the status register is read.
// - Auto-command flag is high when any of bits 0 to 4 is set.
// - Bit 7 never contributes to the auto-command flag.
module eim_err_irq #(
    parameter int unsigned TIMEOUT_CLKS = eim_pkg::RESP_TIMEOUT_CARD_CLKS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [eim_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [eim_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] err_status,
    input wire eim_pkg::eim_acmd_ev_t acmd_ev,
    input wire logic card_clk_tick,
    input wire logic queued_command_without_data,
    output logic err_irq,
    output logic acmd_err_flag,
    output logic [15:0] acmd_status,
    output eim_pkg::eim_fault_t acmd_fault
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // Register select: 0 none, 1 line enable, 2 auto-command status
    function automatic logic [1:0] reg_sel(input logic [eim_pkg::ADDR_W-1:0] a);
        reg_sel = (a == eim_pkg::ADDR_LINE_EN) ? 2'h1
            : (a == eim_pkg::ADDR_ACMD_ST) ? 2'h2 : 2'h0;
    endfunction

    // Joint decode of CRC and timeout bits
    function automatic eim_pkg::eim_fault_t fault_of(input logic crc, input logic tmo);
        unique case ({crc, tmo})
            2'b00: fault_of = eim_pkg::EIM_FAULT_NONE;
            2'b01: fault_of = eim_pkg::EIM_FAULT_TIMEOUT;
            2'b10: fault_of = eim_pkg::EIM_FAULT_CRC;
            2'b11: fault_of = eim_pkg::EIM_FAULT_CONFLICT;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [15:0] line_en_reg;
    logic [4:0] st_lo_reg;
    logic st_b7_reg;
    logic src_cmd23_reg;
    logic aw_full_reg;
    logic [eim_pkg::ADDR_W-1:0] aw_addr_reg;
    logic w_full_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [15:0] line_en_next;
    logic st_b7_next;
    logic [15:0] st_view;
    logic [15:0] eff_status;
    logic wr_fire;
    logic rd_fire;
    logic rd_status;
    logic tmr_expired;
    logic cmd23_done;

    // ----------------------------------------------------------------
    // Write channel
    // ----------------------------------------------------------------
    // Address and data may arrive in either order
    assign s_axi_awready = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready = !w_full_reg && !bvalid_reg;
    assign wr_fire = aw_full_reg && w_full_reg;

    // Hold write address until paired with data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_full_reg <= 1'b0;
        end
    end

    // Hold write data until paired with address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_full_reg <= 1'b0;
        end
    end

    // Write response; unmapped address gets SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= eim_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (reg_sel(aw_addr_reg) == 2'h0) ? eim_pkg::RESP_SLVERR
                                                      : eim_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // ----------------------------------------------------------------
    // Line enable register
    // ----------------------------------------------------------------
    // Byte lanes 0 and 1 only; reserved bit never stored
    always_comb begin
        line_en_next = line_en_reg;
        if (w_strb_reg[0]) begin
            line_en_next[7:0] = w_data_reg[7:0];
        end
        if (w_strb_reg[1]) begin
            line_en_next[15:8] = w_data_reg[15:8];
        end
        line_en_next = line_en_next & eim_pkg::LINE_EN_WMASK;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_en_reg <= eim_pkg::LINE_EN_RESET;
        end else if (wr_fire && reg_sel(aw_addr_reg) == 2'h1) begin
            line_en_reg <= line_en_next;
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    assign s_axi_arready = !rvalid_reg;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_status = rd_fire && reg_sel(s_axi_araddr) == 2'h2;

    // Bit 7 value sampled at the read: pending command blocked by stop error
    assign st_b7_next = queued_command_without_data && !src_cmd23_reg
                        && (|st_lo_reg[4:1]);

    // Read data captured with bit 7 already refreshed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= eim_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= eim_pkg::RESP_OKAY;
            unique case (reg_sel(s_axi_araddr))
                2'h1: rdata_reg <= {16'h0000, line_en_reg};
                2'h2: rdata_reg <= {16'h0000, 8'h00, st_b7_next, 2'b00, st_lo_reg};
                default: begin
                    rdata_reg <= '0;
                    rresp_reg <= eim_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // ----------------------------------------------------------------
    // Response timeout
    // ----------------------------------------------------------------
    eim_resp_timer #(
        .LIMIT(TIMEOUT_CLKS)
    ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(acmd_ev.cmd_end),
        .stop(acmd_ev.resp_end),
        .tick(card_clk_tick),
        .expired(tmr_expired)
    );

    // Which command the outstanding response belongs to
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_cmd23_reg <= 1'b0;
        end else if (acmd_ev.cmd_end || acmd_ev.issue_req) begin
            src_cmd23_reg <= acmd_ev.is_cmd23;
        end
    end

    assign cmd23_done = (acmd_ev.resp_end && acmd_ev.is_cmd23)
                        || (tmr_expired && !acmd_ev.resp_end && src_cmd23_reg);

    // ----------------------------------------------------------------
    // Auto-command status bits 4 to 0
    // ----------------------------------------------------------------
    // Response evaluation wins over issue and timeout in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_lo_reg <= eim_pkg::ST_LO_RESET;
        end else begin
            if (acmd_ev.issue_req && !acmd_ev.is_cmd23) begin
                // Blocked only counts once the transfer started
                st_lo_reg[eim_pkg::ST_NOT_EXECUTED] <= acmd_ev.blocked
                    && acmd_ev.xfer_started;
            end
            if (tmr_expired && !acmd_ev.resp_end) begin
                st_lo_reg[eim_pkg::ST_TIMEOUT] <= 1'b1;
                st_lo_reg[eim_pkg::ST_CRC] <= 1'b0;
                st_lo_reg[eim_pkg::ST_END_BIT] <= 1'b0;
                st_lo_reg[eim_pkg::ST_INDEX] <= 1'b0;
            end
            if (acmd_ev.resp_end) begin
                st_lo_reg[eim_pkg::ST_INDEX] <= acmd_ev.index_err;
                st_lo_reg[eim_pkg::ST_END_BIT] <= acmd_ev.end_bit_err;
                st_lo_reg[eim_pkg::ST_CRC] <= acmd_ev.crc_err;
                st_lo_reg[eim_pkg::ST_TIMEOUT] <= 1'b0;
            end
            if (cmd23_done) begin
                st_lo_reg[eim_pkg::ST_NOT_EXECUTED] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Command not issued bit
    // ----------------------------------------------------------------
    // Block-count errors clear it; otherwise refreshed at each status read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_b7_reg <= eim_pkg::ST_B7_RESET;
        end else if (cmd23_done) begin
            st_b7_reg <= 1'b0;
        end else if (rd_status) begin
            st_b7_reg <= st_b7_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Status view with reserved bits zero
    assign st_view = {8'h00, st_b7_reg, 2'b00, st_lo_reg};

    // Flag from bits 4 to 0 only
    assign acmd_err_flag = |st_lo_reg;

    // Own auto-command flag joins the external status word
    always_comb begin
        eff_status = err_status;
        eff_status[eim_pkg::EN_AUTO_CMD] = err_status[eim_pkg::EN_AUTO_CMD] | acmd_err_flag;
    end

    // Status registered for the status path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acmd_status <= '0;
            acmd_fault <= eim_pkg::EIM_FAULT_NONE;
        end else begin
            acmd_status <= st_view;
            acmd_fault <= fault_of(st_lo_reg[eim_pkg::ST_CRC],
                                   st_lo_reg[eim_pkg::ST_TIMEOUT]);
        end
    end

    // Single shared line, masked per bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_irq <= 1'b0;
        end else begin
            err_irq <= |(eff_status & line_en_reg);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    AST_IRQ_MASKED: assert property (~|(eff_status & line_en_reg) |=> !err_irq)
        else $error("line raised while masked");
    AST_IRQ_RAISED: assert property (|(eff_status & line_en_reg) |=> err_irq)
        else $error("enabled status did not raise line");
    AST_EN_RSVD: assert property (!line_en_reg[eim_pkg::EN_RSVD])
        else $error("reserved enable bit set");
    AST_ST_RSVD: assert property (~|{acmd_status[15:8], acmd_status[6:5]})
        else $error("reserved status bits set");
    AST_INDEX: assert property (acmd_ev.resp_end |=>
        st_lo_reg[4] == $past(acmd_ev.index_err) && st_lo_reg[3] == $past(acmd_ev.end_bit_err)
        && st_lo_reg[2] == $past(acmd_ev.crc_err)) else $error("response error bits wrong");
    AST_TIMEOUT: assert property (tmr_expired && !acmd_ev.resp_end
        |=> st_lo_reg[4:1] == 4'h1) else $error("timeout not recorded");
    AST_RESP_CLR_TMO: assert property (acmd_ev.resp_end
        |=> !st_lo_reg[eim_pkg::ST_TIMEOUT]) else $error("timeout bit not cleared at response");
    AST_ISSUE: assert property (acmd_ev.issue_req && !acmd_ev.is_cmd23 && !cmd23_done
        |=> st_lo_reg[0] == ($past(acmd_ev.blocked) && $past(acmd_ev.xfer_started)))
        else $error("not executed bit wrong at issue");
    AST_NOT_STARTED: assert property (acmd_ev.issue_req && !acmd_ev.is_cmd23
        && !acmd_ev.xfer_started |=> !st_lo_reg[0])
        else $error("not executed set without transfer");
    AST_CMD23_CLR: assert property (cmd23_done |=> !st_lo_reg[0] && !st_b7_reg)
        else $error("block-count error left bit 0 or 7 set");
    AST_B7_READ: assert property (rd_status && !cmd23_done
        |=> st_b7_reg == $past(st_b7_next) && s_axi_rdata[7] == st_b7_reg)
        else $error("bit 7 not refreshed at read");
    AST_FLAG: assert property (st_b7_reg && st_lo_reg == 5'h00 |-> !acmd_err_flag)
        else $error("bit 7 alone raised flag");
    AST_FLAG_SET: assert property (st_lo_reg != 5'h00 |-> acmd_err_flag)
        else $error("flag missing");
    AST_FAULT: assert property (st_lo_reg[2:1] == 2'b11
        |=> acmd_fault == eim_pkg::EIM_FAULT_CONFLICT) else $error("conflict not decoded");
    AST_RESET: assert property (!$past(aresetn)
        |-> line_en_reg == 16'h0000 && st_lo_reg == 5'h00) else $error("reset values wrong");
    COV_TIMEOUT: cover property (tmr_expired ##1 acmd_err_flag);
    COV_CONFLICT: cover property (acmd_fault == eim_pkg::EIM_FAULT_CONFLICT);
    COV_B7: cover property (rd_status ##1 st_b7_reg);
    COV_IRQ: cover property (!err_irq ##1 err_irq);

endmodule // eim_err_irq

//--- verification/eim_host_model.sv
// Host side model: interrupt input and driver view of the auto-command status
`timescale 1ns/1ps
module eim_host_model (
    input wire logic aclk,
    input wire logic err_irq,
    input wire logic acmd_err_flag,
    input wire logic [15:0] acmd_status,
    output logic irq_seen,
    output logic [15:0] sw_status
);
    // Host samples the shared line once a cycle
    always_ff @(posedge aclk) begin
        irq_seen <= err_irq;
    end
    // Driver view: status only with the flag, bits 4:2 dropped on timeout
    assign sw_status = !acmd_err_flag ? 16'h0000
        : (acmd_status[1] ? (acmd_status & 16'hffe3) : acmd_status);
endmodule // eim_host_model

//--- verification/test_eim_err_irq.sv
// Self-checking bench for the error line mask and auto-command status block
`timescale 1ns/1ps
module test_eim_err_irq;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic card_clk_tick, queued_command_without_data, err_irq, acmd_err_flag, irq_seen;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [15:0] err_status, acmd_status, sw_status;
    eim_pkg::eim_acmd_ev_t acmd_ev;
    eim_pkg::eim_fault_t acmd_fault;
    int errors = 0, tests_run = 0, cycles = 0;
    eim_err_irq #(.TIMEOUT_CLKS(4)) i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .err_status(err_status),
        .acmd_ev(acmd_ev), .card_clk_tick(card_clk_tick),
        .queued_command_without_data(queued_command_without_data), .err_irq(err_irq),
        .acmd_err_flag(acmd_err_flag), .acmd_status(acmd_status), .acmd_fault(acmd_fault));
    eim_host_model i_host (.aclk(aclk), .err_irq(err_irq), .acmd_err_flag(acmd_err_flag),
        .acmd_status(acmd_status), .irq_seen(irq_seen), .sw_status(sw_status));
    // Clock source
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // Card clock tick every other cycle and hang guard
    always @(posedge aclk) begin
        card_clk_tick <= ~card_clk_tick;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            $display("[ERR] run timed out");
            conclude;
        end
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ad = 0, wd = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd)) begin
            @(negedge aclk);
            ad = ad | s_axi_awready;
            wd = wd | s_axi_wready;
            @(posedge aclk);
            if (ad) s_axi_awvalid <= 1'b0;
            if (wd) s_axi_wvalid <= 1'b0;
        end
        do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        @(posedge aclk) s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (s_axi_arready !== 1'b1);
        @(posedge aclk) s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge aclk) s_axi_rready <= 1'b0;
    endtask
    // One event pulse, then settle and sample off the edge
    task automatic ev(input logic [8:0] e);
        @(posedge aclk) acmd_ev <= e;
        @(posedge aclk) acmd_ev <= 9'h000;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic st(input logic [15:0] exp);
        chk("acmd_status", {16'h0, exp}, {16'h0, acmd_status});
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_and_map;
        rd(eim_pkg::ADDR_LINE_EN, rdv, rr);
        chk("line_en reset", 32'h0, rdv);
        wr(eim_pkg::ADDR_ACMD_ST, 32'h0000_ffff, rr);
        rd(eim_pkg::ADDR_ACMD_ST, rdv, rr);
        chk("status reset", 32'h0, rdv);
        wr(8'h00, 32'h1, rr);
        chk("unmapped bresp", 32'(eim_pkg::RESP_SLVERR), 32'(rr));
        rd(8'h04, rdv, rr);
        chk("unmapped rresp", 32'(eim_pkg::RESP_SLVERR), 32'(rr));
        $display("test reset_and_map done");
    endtask
    task automatic t_mask;
        @(posedge aclk) err_status <= 16'hffff;
        for (int i = 0; i < 16; i++) begin
            wr(eim_pkg::ADDR_LINE_EN, 32'h1 << i, rr);
            rd(eim_pkg::ADDR_LINE_EN, rdv, rr);
            chk("line_en", 32'(16'hf7ff & (16'h1 << i)), rdv);
            chk("err_irq", {31'h0, i != 11}, {31'h0, irq_seen});
        end
        wr(eim_pkg::ADDR_LINE_EN, 32'h0000_0100, rr);
        @(posedge aclk) err_status <= 16'h0000;
        repeat (3) @(negedge aclk);
        chk("err_irq masked", 32'h0, {31'h0, err_irq});
        $display("test mask done");
    endtask
    task automatic t_resp;
        for (int k = 0; k < 8; k++) begin
            ev(9'h010);
            ev(9'(8 + k));
            st(16'(k << 2));
            chk("flag", {31'h0, k != 0}, {31'h0, acmd_err_flag});
            chk("fault", {30'h0, k[0], 1'b0}, {30'h0, acmd_fault});
        end
        $display("test resp done");
    endtask
    task automatic t_timeout;
        ev(9'h010);
        repeat (20) @(negedge aclk);
        st(16'h0002);
        chk("fault", 32'(eim_pkg::EIM_FAULT_TIMEOUT), {30'h0, acmd_fault});
        chk("err_irq", 32'h1, {31'h0, err_irq});
        chk("sw view", 32'h2, {16'h0, sw_status});
        @(posedge aclk) queued_command_without_data <= 1'b1;
        rd(eim_pkg::ADDR_ACMD_ST, rdv, rr);
        chk("bit7 set", 32'h82, rdv);
        chk("flag", 32'h1, {31'h0, acmd_err_flag});
        @(posedge aclk) queued_command_without_data <= 1'b0;
        rd(eim_pkg::ADDR_ACMD_ST, rdv, rr);
        chk("bit7 clear", 32'h2, rdv);
        $display("test timeout done");
    endtask
    task automatic t_stop_and_cmd23;
        ev(9'h1c0);
        st(16'h0003);
        ev(9'h180);
        st(16'h0002);
        ev(9'h1c0);
        ev(9'h100);
        st(16'h0002);
        ev(9'h1c0);
        @(posedge aclk) queued_command_without_data <= 1'b1;
        ev(9'h030);
        ev(9'h029);
        st(16'h0004);
        rd(eim_pkg::ADDR_ACMD_ST, rdv, rr);
        chk("bit7 cmd23", 32'h4, rdv);
        chk("fault", 32'(eim_pkg::EIM_FAULT_CRC), {30'h0, acmd_fault});
        $display("test stop_and_cmd23 done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, err_status} = '0;
        {card_clk_tick, queued_command_without_data} = '0;
        s_axi_wstrb = 4'hf;
        acmd_ev = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_and_map;
        t_mask;
        t_resp;
        t_timeout;
        t_stop_and_cmd23;
        conclude;
    end
endmodule // test_eim_err_irq
